//--- mil_defines.vh
`ifndef MIL_DEFINES_VH
`define MIL_DEFINES_VH

// Register offsets on the local register port
`define MIL_OFS_PORT_B 8'h06
`define MIL_OFS_IRQ_CTRL 8'h0B
`define MIL_OFS_PERIPH_FLAG 8'h0C
`define MIL_OFS_OPTION 8'h81
`define MIL_OFS_PERIPH_EN 8'h8C

// Interrupt control register fields
`define MIL_BIT_GIE 7
`define MIL_BIT_PERIPH_GROUP_EN 6
`define MIL_BIT_TIMER_EN 5
`define MIL_BIT_EXT_EN 4
`define MIL_BIT_PORT_EN 3
`define MIL_BIT_TIMER_FLAG 2
`define MIL_BIT_EXT_FLAG 1
`define MIL_BIT_PORT_FLAG 0

// Option register edge select, peripheral comparator bit
`define MIL_BIT_EDGE_SEL 6
`define MIL_BIT_CMP 6

// Reset values
`define MIL_RST_IRQ_CTRL 8'h00
`define MIL_RST_OPTION 8'hFF
`define MIL_RST_PERIPH_FLAG 8'h00
`define MIL_RST_PERIPH_EN 8'h00

// Interrupt vector and timer rollover values
`define MIL_VECTOR 13'h0004
`define MIL_TMR_MAX 8'hFF
`define MIL_TMR_ZERO 8'h00

`endif

//--- mil_sync.v
// Two flop synchroniser for pin inputs
module mil_sync #(
   parameter W = 1
) (
   input wire clk,              // Instruction clock
   input wire reset_n,          // Synchronous reset, active low
   input wire [W-1:0] d,        // Asynchronous input
   output wire [W-1:0] q        // Synchronised output
);

   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   // First stage read only by second stage
   always @(posedge clk) begin
      if (!reset_n) begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end else begin
         meta_r <= d;
         sync_r <= meta_r;
      end
   end

   assign q = sync_r;

endmodule

//--- mil_intc.v
// Behaviour
// - Four sources: external edge pin, timer overflow, port change, comparator.
// - Global enable at control bit 7 passes unmasked requests, else blocks all.
// - Every reset clears the global enable.
// - Return-from-interrupt instruction sets the global enable again.
// - On entry clear global enable, push return address, load PC 0004h.
// - Pin and port-change latency to vector is four or five cycles.
// - Flags set by events regardless of individual or global enables.
// - Clearing global enable ignores next-cycle requests, inserts a no-op; requests stay pending.
// - External pin edge chosen by option bit 6: set rising, clear falling.
// - Selected pin edge sets external flag at control bit 1.
// - Clearing control bit 4 disables the external pin interrupt.
// - Enabled pin interrupt wakes from sleep; global enable decides vectoring.
// - Timer rollover FFh to 00h sets timer flag at control bit 2.
// - Control bit 5 enables the timer overflow interrupt.
// - Change on port pins 7..4 sets port flag at bit 0; enable at control bit 3.
// - Port change coinciding with a port read may miss the flag.
// - Comparator flag and enable live in separate peripheral registers.
// - Entry saves only the return PC; no working or status registers.
// - Enabled interrupt wakes regardless of global enable; vector after prefetched instruction.
// - Pending enabled source at sleep entry wakes immediately.
`include "mil_defines.vh"

module mil_intc (
   input wire clk,                    // Instruction clock
   input wire reset_n,                // Synchronous reset, active low
   input wire [7:0] reg_addr,         // Register address
   input wire [7:0] reg_wdata,        // Register write data
   input wire reg_wr,                 // Write strobe
   input wire reg_rd,                 // Read strobe
   output wire [7:0] reg_rdata,       // Read data, cycle after strobe
   input wire ext_irq_pin,            // External interrupt pin
   input wire [3:0] port_b_pins,      // Port pins 7..4
   input wire [7:0] timer_count_reg,  // Timer count value
   input wire cmp_event,              // Comparator output change pulse
   input wire return_from_irq_instr,  // Return instruction executed
   input wire sleep_enter,            // Sleep instruction executed
   output wire irq_req,               // Qualified request to core
   output wire vec_load,              // Load PC with vector, pulse
   output wire [12:0] vec_addr,       // Vector address
   output wire push_pc,               // Push return PC, pulse
   output wire nop_insert,            // Execute no-op this cycle
   output wire wake,                  // Wake-up pulse
   output wire sleeping               // Core held in sleep
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   localparam ST_RUN = 2'b00;
   localparam ST_SLEEP = 2'b01;
   localparam ST_WAKE = 2'b10;

   reg [7:0] irq_control_reg_r;
   reg [7:0] irq_control_reg_nxt;
   reg [7:0] option_r;
   reg [7:0] periph_flag_reg_r;
   reg [7:0] periph_flag_reg_nxt;
   reg [7:0] periph_enable_reg_r;
   reg [7:0] rdata_r;
   reg [7:0] rdata_nxt;
   reg ext_prev_r;
   reg [3:0] port_latch_r;
   reg [7:0] tmr_prev_r;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg block_r;
   reg vec_load_r;
   reg push_pc_r;
   reg [12:0] vec_addr_r;
   reg wake_r;
   reg vec_go;
   reg wake_go;
   reg [2:0] arm_r;

   wire ext_sync;
   wire [3:0] port_sync;
   wire wr_ctrl;
   wire wr_opt;
   wire wr_pflag;
   wire wr_pen;
   wire rd_port;
   wire edge_sel;
   wire ext_edge;
   wire port_change;
   wire tmr_roll;
   wire src_ext;
   wire src_tmr;
   wire src_port;
   wire src_cmp;
   wire pend;
   wire global_irq_enable;
   wire gie_clear_wr;
   wire armed;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   // Pin inputs pass two flops before use
   mil_sync #(
      .W(5)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .d({ext_irq_pin, port_b_pins}),
      .q({ext_sync, port_sync})
   );

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   assign wr_ctrl = reg_wr && (reg_addr == `MIL_OFS_IRQ_CTRL);
   assign wr_opt = reg_wr && (reg_addr == `MIL_OFS_OPTION);
   assign wr_pflag = reg_wr && (reg_addr == `MIL_OFS_PERIPH_FLAG);
   assign wr_pen = reg_wr && (reg_addr == `MIL_OFS_PERIPH_EN);
   assign rd_port = reg_rd && (reg_addr == `MIL_OFS_PORT_B);

   ////////////////////////////////////////////////////////////////////////
   // Event detection

   assign edge_sel = option_r[`MIL_BIT_EDGE_SEL];

   // Pin edge and port-change detectors wait until synchronisers hold real pin levels after reset
   assign armed = arm_r[2];

   assign ext_edge = armed && (edge_sel ? (ext_sync && !ext_prev_r) : (!ext_sync && ext_prev_r));

   assign tmr_roll = (tmr_prev_r == `MIL_TMR_MAX) && (timer_count_reg == `MIL_TMR_ZERO);

   assign port_change = armed && (port_sync != port_latch_r) && !rd_port;

   // Previous values for edge and mismatch detection
   always @(posedge clk) begin
      if (!reset_n) begin
         ext_prev_r <= 1'b0;
         tmr_prev_r <= 8'h00;
         port_latch_r <= 4'h0;
         arm_r <= 3'h0;
      end else begin
         ext_prev_r <= ext_sync;
         tmr_prev_r <= timer_count_reg;
         // Fills with ones over three edges after reset
         arm_r <= {arm_r[1:0], 1'b1};
         // port read reloads latch
         // Latch also tracks the pins until the detectors are armed
         if (rd_port || !armed) begin
            port_latch_r <= port_sync;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flag and enable registers

   assign global_irq_enable = irq_control_reg_r[`MIL_BIT_GIE];
   assign gie_clear_wr = wr_ctrl && !reg_wdata[`MIL_BIT_GIE] && global_irq_enable;

   // Next value of control register
   always @* begin
      irq_control_reg_nxt = irq_control_reg_r;
      if (wr_ctrl) begin
         irq_control_reg_nxt = reg_wdata;
      end
      if (ext_edge) begin
         irq_control_reg_nxt[`MIL_BIT_EXT_FLAG] = 1'b1;
      end
      if (tmr_roll) begin
         irq_control_reg_nxt[`MIL_BIT_TIMER_FLAG] = 1'b1;
      end
      if (port_change) begin
         irq_control_reg_nxt[`MIL_BIT_PORT_FLAG] = 1'b1;
      end
      if (vec_go) begin
         irq_control_reg_nxt[`MIL_BIT_GIE] = 1'b0;
      end
      if (return_from_irq_instr) begin
         irq_control_reg_nxt[`MIL_BIT_GIE] = 1'b1;
      end
   end

   // Next value of peripheral flag register
   always @* begin
      periph_flag_reg_nxt = periph_flag_reg_r;
      if (wr_pflag) begin
         periph_flag_reg_nxt = reg_wdata & (8'h01 << `MIL_BIT_CMP);
      end
      if (cmp_event) begin
         periph_flag_reg_nxt[`MIL_BIT_CMP] = 1'b1;
      end
   end

   // Register storage
   always @(posedge clk) begin
      if (!reset_n) begin
         irq_control_reg_r <= `MIL_RST_IRQ_CTRL;
         option_r <= `MIL_RST_OPTION;
         periph_flag_reg_r <= `MIL_RST_PERIPH_FLAG;
         periph_enable_reg_r <= `MIL_RST_PERIPH_EN;
      end else begin
         irq_control_reg_r <= irq_control_reg_nxt;
         periph_flag_reg_r <= periph_flag_reg_nxt;
         if (wr_opt) begin
            option_r <= reg_wdata;
         end
         if (wr_pen) begin
            periph_enable_reg_r <= reg_wdata & (8'h01 << `MIL_BIT_CMP);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Request combination

   assign src_ext = irq_control_reg_r[`MIL_BIT_EXT_FLAG] && irq_control_reg_r[`MIL_BIT_EXT_EN];
   assign src_tmr = irq_control_reg_r[`MIL_BIT_TIMER_FLAG] && irq_control_reg_r[`MIL_BIT_TIMER_EN];
   assign src_port = irq_control_reg_r[`MIL_BIT_PORT_FLAG] && irq_control_reg_r[`MIL_BIT_PORT_EN];
   assign src_cmp = periph_flag_reg_r[`MIL_BIT_CMP] && periph_enable_reg_r[`MIL_BIT_CMP]
                    && irq_control_reg_r[`MIL_BIT_PERIPH_GROUP_EN];

   assign pend = src_ext || src_tmr || src_port || src_cmp;

   assign irq_req = pend && global_irq_enable;

   ////////////////////////////////////////////////////////////////////////
   // Sleep and vector control

   // State, vector and wake decisions
   always @* begin
      state_nxt = state_r;
      vec_go = 1'b0;
      wake_go = 1'b0;
      case (state_r)
         ST_RUN: begin
            // no vector beside an enable-clearing write
            if (irq_req && !block_r && !gie_clear_wr && !sleep_enter) begin
               vec_go = 1'b1;
            end else if (sleep_enter) begin
               if (pend) begin
                  wake_go = 1'b1;
                  state_nxt = global_irq_enable ? ST_WAKE : ST_RUN;
               end else begin
                  state_nxt = ST_SLEEP;
               end
            end
         end
         ST_SLEEP: begin
            if (pend) begin
               wake_go = 1'b1;
               state_nxt = global_irq_enable ? ST_WAKE : ST_RUN;
            end
         end
         ST_WAKE: begin
            state_nxt = ST_RUN;
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   // Control flops
   always @(posedge clk) begin
      if (!reset_n) begin
         state_r <= ST_RUN;
         block_r <= 1'b0;
         vec_load_r <= 1'b0;
         push_pc_r <= 1'b0;
         vec_addr_r <= 13'h0000;
         wake_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         block_r <= gie_clear_wr;
         vec_load_r <= vec_go;
         push_pc_r <= vec_go;
         if (vec_go) begin
            vec_addr_r <= `MIL_VECTOR;
         end
         wake_r <= wake_go;
      end
   end

   assign vec_load = vec_load_r;
   assign push_pc = push_pc_r;
   assign vec_addr = vec_addr_r;
   assign wake = wake_r;
   assign nop_insert = block_r;
   assign sleeping = (state_r == ST_SLEEP);

   ////////////////////////////////////////////////////////////////////////
   // Register read port

   // Read data selected by address
   always @* begin
      rdata_nxt = 8'h00;
      case (reg_addr)
         `MIL_OFS_IRQ_CTRL: rdata_nxt = irq_control_reg_r;
         `MIL_OFS_OPTION: rdata_nxt = option_r;
         `MIL_OFS_PERIPH_FLAG: rdata_nxt = periph_flag_reg_r;
         `MIL_OFS_PERIPH_EN: rdata_nxt = periph_enable_reg_r;
         `MIL_OFS_PORT_B: rdata_nxt = {port_sync, 4'h0};
         default: rdata_nxt = 8'h00;
      endcase
   end

   // Data valid only in cycle after strobe
   always @(posedge clk) begin
      if (!reset_n) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign reg_rdata = rdata_r;

endmodule

//--- mil_core_model.sv
module mil_core_model (
   input logic clk, // Clock
   input logic reset_n, // Reset, active low
   input logic push_pc, // Return address push
   input logic ret_req, // Return command
   input logic sleep_req, // Sleep command
   output logic return_from_irq_instr = 1'b0, // Return pulse
   output logic sleep_enter = 1'b0, // Sleep pulse
   output logic [3:0] depth = 4'h0 // Stack depth
);
   timeunit 1ns;
   timeprecision 1ps;
   // Core issues instructions, stack holds return PCs only
   // PC only saved
   always @(posedge clk) begin
      if (!reset_n) begin
         return_from_irq_instr <= 1'b0;
         sleep_enter <= 1'b0;
         depth <= 4'h0;
      end else begin
         return_from_irq_instr <= ret_req;
         sleep_enter <= sleep_req;
         depth <= depth + {3'h0, push_pc} - {3'h0, ret_req};
      end
   end
endmodule

//--- mil_intc_monitor.sv
module mil_intc_mon (
   input logic clk, // Clock
   input logic reset_n, // Reset, active low
   input logic [7:0] reg_addr, // Address
   input logic [7:0] reg_wdata, // Write data
   input logic reg_wr, // Write strobe
   input logic reg_rd, // Read strobe
   input logic [7:0] reg_rdata, // Read data
   input logic [7:0] timer_count_reg, // Timer value
   input logic return_from_irq_instr, // Return
   input logic sleep_enter, // Sleep
   input logic irq_req, // Request
   input logic vec_load, // Vector load
   input logic [12:0] vec_addr, // Vector
   input logic push_pc, // Push
   input logic nop_insert, // No-op
   input logic sleeping // Asleep
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   //////////////////////////////
   // Steps of read, rollover and return
   sequence ctrl_rd_s; reg_rd && reg_addr == 8'h0B; endsequence
   sequence roll_s; timer_count_reg == 8'hFF ##1 timer_count_reg == 8'h00; endsequence
   sequence ret_s; return_from_irq_instr; endsequence
   rst_quiet_a: assert property (disable iff (1'b0) !reset_n |=> !vec_load && !irq_req && !sleeping)
      else $error("outputs active after reset");
   vec_pair_a: assert property (vec_load == push_pc) else $error("push and vector differ");
   vec_addr_a: assert property (vec_load |-> vec_addr == 13'h0004) else $error("wrong vector");
   vec_cause_a: assert property (vec_load |-> $past(irq_req)) else $error("vector without request");
   gie_drop_a: assert property (vec_load |-> !irq_req) else $error("enable kept on entry");
   gie_return_a: assert property (ret_s ##1 ctrl_rd_s |=> reg_rdata[7])
      else $error("return left enable clear");
   timer_flag_a: assert property (roll_s ##2 ctrl_rd_s |=> reg_rdata[2])
      else $error("rollover flag missing");
   nop_cause_a: assert property (nop_insert |-> $past(reg_wr && reg_addr == 8'h0B && !reg_wdata[7]))
      else $error("no-op without enable clear");
   nop_block_a: assert property (nop_insert |=> !vec_load) else $error("vector after no-op");
   nop_excl_a: assert property (nop_insert |-> !vec_load) else $error("vector beside no-op");
   sleep_cause_a: assert property ($rose(sleeping) |-> $past(sleep_enter)) else $error("sleep uncommanded");
endmodule

//--- tb_mil_intc.sv
module tb_mil_intc;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset_n, reg_wr, reg_rd, ext_irq_pin, cmp_event, ret_req, sleep_req, rd_q;
   logic return_from_irq_instr, sleep_enter, irq_req, vec_load, push_pc, nop_insert, wake, sleeping;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, timer_count_reg, lf;
   logic [3:0] port_b_pins, depth;
   logic [12:0] vec_addr;
   logic [15:0] exp_q[$];
   logic [15:0] note;
   int miscompares = 0;
   int n_tests = 0;
   int n_vec = 0, n_nop = 0, n_wake = 0, n;
   mil_intc DUT (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_irq_pin,
      .port_b_pins, .timer_count_reg, .cmp_event, .return_from_irq_instr, .sleep_enter, .irq_req,
      .vec_load, .vec_addr, .push_pc, .nop_insert, .wake, .sleeping);
   mil_core_model u_core (.clk, .reset_n, .push_pc, .ret_req, .sleep_req, .return_from_irq_instr,
      .sleep_enter, .depth);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   //////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task automatic finish_test;
      $display("Counts: %0d checks, %0d mismatches", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      tick(1);
      reg_wr <= 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      exp_q.push_back({m, e});
      reg_addr <= a;
      reg_rd <= 1'b1;
      tick(1);
      reg_rd <= 1'b0;
      tick(1);
   endtask
   task automatic core(input logic ret);
      if (ret) ret_req <= 1'b1;
      else sleep_req <= 1'b1;
      tick(1);
      {ret_req, sleep_req} <= 2'b00;
      tick(1);
   endtask
   task automatic roll;
      timer_count_reg <= 8'hFF;
      tick(1);
      timer_count_reg <= 8'h00;
      tick(2);
   endtask
   // Check read data against the oldest note, count pulses
   always @(posedge clk) begin
      rd_q <= reg_rd;
      n_vec <= n_vec + int'(vec_load === 1'b1);
      n_nop <= n_nop + int'(nop_insert === 1'b1);
      n_wake <= n_wake + int'(wake === 1'b1);
      if (rd_q === 1'b1) begin
         note = exp_q.pop_front();
         chk((reg_rdata & note[15:8]) === note[7:0], "read data mismatch");
      end
   end
   bit s;
   initial begin
      {reset_n, reg_wr, reg_rd, ext_irq_pin, cmp_event, ret_req, sleep_req} = 7'h00;
      {reg_addr, reg_wdata, timer_count_reg} = 24'h000000;
      port_b_pins = 4'h0;
      lf = 8'h15;
      tick(4);
      reset_n <= 1'b1;
      tick(3);
      rd(8'h0B, 8'hFF, 8'h00);
      rd(8'h81, 8'hFF, 8'hFF);
      rd(8'h0C, 8'hFF, 8'h00);
      rd(8'h8C, 8'hFF, 8'h00);
      rd(8'h33, 8'hFF, 8'h00);
      $display("Test reset done");
      for (int i = 1; i >= 0; i--) begin
         s = i[0];
         wr(8'h81, s ? 8'hFF : 8'hBF);
         ext_irq_pin <= !s;
         tick(4);
         wr(8'h0B, 8'h00);
         ext_irq_pin <= s;
         tick(5);
         rd(8'h0B, 8'h02, 8'h02);
         wr(8'h0B, 8'h00);
         ext_irq_pin <= !s;
         tick(5);
         rd(8'h0B, 8'h02, 8'h00);
      end
      for (int i = 0; i < 16; i++) begin
         lf = lfsr(lf);
         timer_count_reg <= lf & 8'h7F;
         tick(1);
      end
      rd(8'h0B, 8'h04, 8'h00);
      roll();
      rd(8'h0B, 8'h04, 8'h04);
      rd(8'h06, 8'hF0, {port_b_pins, 4'h0});
      wr(8'h0B, 8'h00);
      lf = lfsr(lf);
      port_b_pins <= port_b_pins ^ (lf[3:0] | 4'h1);
      tick(5);
      rd(8'h0B, 8'h01, 8'h01);
      rd(8'h06, 8'hF0, {port_b_pins, 4'h0});
      wr(8'h0B, 8'h00);
      tick(3);
      rd(8'h0B, 8'h01, 8'h00);
      cmp_event <= 1'b1;
      tick(1);
      cmp_event <= 1'b0;
      tick(1);
      rd(8'h0C, 8'h40, 8'h40);
      wr(8'h0C, 8'h00);
      rd(8'h0C, 8'h40, 8'h00);
      $display("Test flags done");
      wr(8'h81, 8'hFF);
      ext_irq_pin <= 1'b0;
      tick(4);
      wr(8'h0B, 8'h90);
      ext_irq_pin <= 1'b1;
      n = 0;
      do begin
         tick(1);
         n++;
      end while (vec_load !== 1'b1 && n < 12);
      chk(n >= 4 && n <= 5, "vector latency");
      if (n == 12) finish_test();
      chk(vec_addr === 13'h0004, "vector address");
      tick(1);
      chk(depth === 4'h1, "return address not pushed");
      rd(8'h0B, 8'h82, 8'h02);
      wr(8'h0B, 8'h10);
      core(1'b1);
      rd(8'h0B, 8'h80, 8'h80);
      tick(4);
      chk(n_vec === 1 && depth === 4'h0, "request recurred");
      wr(8'h0B, 8'h80);
      ext_irq_pin <= 1'b0;
      tick(3);
      ext_irq_pin <= 1'b1;
      tick(6);
      rd(8'h0B, 8'h02, 8'h02);
      chk(n_vec === 1, "masked pin vectored");
      // Enable-clearing write lands while a request is due
      reg_addr <= 8'h0B;
      reg_wdata <= 8'h92;
      reg_wr <= 1'b1;
      tick(1);
      reg_wdata <= 8'h12;
      tick(1);
      reg_wr <= 1'b0;
      tick(4);
      chk(n_nop === 1 && n_vec === 1, "no-op or early vector");
      wr(8'h0B, 8'h92);
      tick(3);
      chk(n_vec === 2, "pending request lost");
      wr(8'h0B, 8'hA0);
      roll();
      tick(3);
      chk(n_vec === 3, "timer vector missing");
      wr(8'h8C, 8'h40);
      wr(8'h0B, 8'hC0);
      cmp_event <= 1'b1;
      tick(1);
      cmp_event <= 1'b0;
      tick(3);
      chk(n_vec === 4, "comparator vector missing");
      wr(8'h0C, 8'h00);
      $display("Test vector done");
      wr(8'h0B, 8'h10);
      ext_irq_pin <= 1'b0;
      core(1'b0);
      tick(3);
      chk(sleeping === 1'b1, "not asleep");
      ext_irq_pin <= 1'b1;
      tick(8);
      chk(n_wake === 1 && sleeping === 1'b0 && n_vec === 4, "pin wake");
      core(1'b0);
      tick(4);
      chk(n_wake === 2 && n_vec === 4, "pending wake");
      wr(8'h0B, 8'h10);
      wr(8'h0B, 8'h90);
      ext_irq_pin <= 1'b0;
      core(1'b0);
      tick(3);
      ext_irq_pin <= 1'b1;
      tick(10);
      chk(n_wake === 3 && n_vec === 5, "wake then vector");
      $display("Test sleep done");
      wr(8'h0B, 8'h80);
      reset_n <= 1'b0;
      tick(2);
      reset_n <= 1'b1;
      tick(4);
      rd(8'h0B, 8'hFF, 8'h00);
      tick(2);
      $display("Test second reset done");
      finish_test();
   end
endmodule
bind mil_intc mil_intc_mon u_mon (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .timer_count_reg, .return_from_irq_instr, .sleep_enter, .irq_req, .vec_load, .vec_addr, .push_pc,
   .nop_insert, .sleeping);
